// ==== src/pit_pkg.sv ====
// package for the prescaled interval timer: register map, field widths, reset values
// assumes a 32-bit classic wishbone register bus, byte addressed, one word per register
package pit_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned PIT_CNT_W   = 16;
  localparam int unsigned PIT_SCL_W   = 8;
  localparam int unsigned PIT_ADR_W   = 4;
  localparam int unsigned PIT_DAT_W   = 32;
  localparam int unsigned PIT_SRC_W   = 7;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [PIT_ADR_W-1:0] PIT_OFS_COUNT  = 4'h0;
  localparam logic [PIT_ADR_W-1:0] PIT_OFS_PERIOD = 4'h4;
  localparam logic [PIT_ADR_W-1:0] PIT_OFS_SCALE  = 4'h8;
  localparam logic [PIT_ADR_W-1:0] PIT_OFS_CTRL   = 4'hc;
  // ************************************************************
  // control register fields and reset values
  // ************************************************************
  localparam int unsigned PIT_CTRL_EN_BIT = 0;
  localparam logic [PIT_CNT_W-1:0] PIT_RST_COUNT  = 16'h0000;
  localparam logic [PIT_CNT_W-1:0] PIT_RST_PERIOD = 16'h0000;
  localparam logic [PIT_SCL_W-1:0] PIT_RST_SCALE  = 8'h00;
  localparam logic                 PIT_RST_EN     = 1'b0;
  // timer source position in the internal interrupt request vector
  localparam int unsigned PIT_TIMER_SRC = 0;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [3:0]           sel;
    logic [PIT_ADR_W-1:0] adr;
    logic [PIT_DAT_W-1:0] dat;
  } pit_wb_req_t;
  typedef struct packed {
    logic                 ack;
    logic [PIT_DAT_W-1:0] dat;
  } pit_wb_rsp_t;
endpackage

// ==== src/pit_timer.sv ====
// prescaled interval timer with a classic wishbone register slave
// assumes one clock, synchronous inputs, and an interrupt controller that takes the request vector
// Summary of operation
// (RULE1) count drops by one every scale+1 cycles
// (RULE2) request interrupt the cycle after a tick that finds count already at zero
// (RULE3) reload count from period at zero
// (RULE4) timer is one of seven internal sources
// (RULE5) prescaler reloads from scale on expiry
`timescale 1ns/10ps
`default_nettype none
module pit_timer (
  input  wire logic                                 CLK,
  input  wire logic                                 RST,
  input  wire pit_pkg::pit_wb_req_t                 WB_REQ,
  output var  pit_pkg::pit_wb_rsp_t                 WB_RSP,
  output var  logic [pit_pkg::PIT_SRC_W-1:0]        INT_SRC
);
  import pit_pkg::*;

  logic [PIT_CNT_W-1:0] count_r;
  logic [PIT_CNT_W-1:0] period_r;
  logic [PIT_SCL_W-1:0] scale_r;
  logic [PIT_SCL_W-1:0] pre_r;
  logic                 en_r;
  logic                 ack_r;
  logic [PIT_DAT_W-1:0] rdat_r;
  logic                 irq_r;
  logic                 access;
  logic                 wr;
  logic                 tick;
  logic                 hit_count;

  // ************************************************************
  // bus decode
  // ************************************************************
  // one wait-free answer: ack one cycle after the request, dropped the next
  // writes land on the edge where the master samples ack high, while the request still stands
  assign access    = WB_REQ.cyc && WB_REQ.stb && !ack_r;
  assign wr        = WB_REQ.cyc && WB_REQ.stb && WB_REQ.we && ack_r;
  assign hit_count = wr && (WB_REQ.adr == PIT_OFS_COUNT) && (&WB_REQ.sel[1:0]);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdat_r <= '0;
    end else if (access && !WB_REQ.we) begin
      case (WB_REQ.adr)
        PIT_OFS_COUNT:  rdat_r <= {16'h0000, count_r};
        PIT_OFS_PERIOD: rdat_r <= {16'h0000, period_r};
        PIT_OFS_SCALE:  rdat_r <= {24'h000000, scale_r};
        PIT_OFS_CTRL:   rdat_r <= {31'h00000000, en_r};
        default:        rdat_r <= '0;
      endcase
    end
  end

  assign WB_RSP = '{ack: ack_r, dat: rdat_r};

  // ************************************************************
  // configuration registers
  // ************************************************************
  // byte lanes: partial writes update only the selected bytes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      period_r <= PIT_RST_PERIOD;
      scale_r  <= PIT_RST_SCALE;
      en_r     <= PIT_RST_EN;
    end else if (wr) begin
      case (WB_REQ.adr)
        PIT_OFS_PERIOD: begin
          if (WB_REQ.sel[0]) period_r[7:0]  <= WB_REQ.dat[7:0];
          if (WB_REQ.sel[1]) period_r[15:8] <= WB_REQ.dat[15:8];
        end
        PIT_OFS_SCALE: begin
          if (WB_REQ.sel[0]) scale_r <= WB_REQ.dat[7:0];
        end
        PIT_OFS_CTRL: begin
          if (WB_REQ.sel[0]) en_r <= WB_REQ.dat[PIT_CTRL_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // prescaler
  // ************************************************************
  // scale n gives one tick every n+1 cycles; n=0 ticks every cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_r <= PIT_RST_SCALE;
    end else if (!en_r) begin
      pre_r <= scale_r;
    end else if (pre_r == '0) begin
      pre_r <= scale_r; // see (RULE5)
    end else begin
      pre_r <= pre_r - 8'h01;
    end
  end

  assign tick = en_r && (pre_r == '0);

  // ************************************************************
  // count register
  // ************************************************************
  // a software write to the count wins over a tick in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      count_r <= PIT_RST_COUNT;
    end else if (hit_count) begin
      count_r <= WB_REQ.dat[15:0];
    end else if (tick) begin
      if (count_r == '0) begin
        count_r <= period_r; // see (RULE3)
      end else begin
        count_r <= count_r - 16'h0001; // see (RULE1)
      end
    end
  end

  // request in the cycle after each tick where the count sits at zero and is not being written
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= tick && (count_r == '0) && !hit_count; // see (RULE2)
    end
  end

  // other internal sources belong to other units and read zero here
  always_comb begin
    INT_SRC                = '0;
    INT_SRC[PIT_TIMER_SRC] = irq_r; // see (RULE4)
  end
endmodule // pit_timer
`default_nettype wire

// ==== test/pit_timer_asserts.sv ====
// checker for the interval timer ports
// assumes binding onto pit_timer
`timescale 1ns/10ps
`default_nettype none
module pit_timer_asserts (
  input wire logic                          CLK,
  input wire logic                          RST,
  input wire pit_pkg::pit_wb_req_t          WB_REQ,
  input wire pit_pkg::pit_wb_rsp_t          WB_RSP,
  input wire logic [pit_pkg::PIT_SRC_W-1:0] INT_SRC
);
  import pit_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_req;
    WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
  endsequence
  a_ack_answers: assert property (s_req |=> WB_RSP.ack) else $error("no ack after request");
  a_ack_pulse: assert property (WB_RSP.ack |=> !WB_RSP.ack) else $error("ack too long");
  a_ack_cause: assert property ($rose(WB_RSP.ack) |-> $past(WB_REQ.stb)) else $error("ack without request");
  a_unmapped_zero: assert property (s_req and !WB_REQ.we && WB_REQ.adr == 4'h2 |=> WB_RSP.dat == 32'h0) else $error("unmapped read");
  a_ack_in_cycle: assert property (WB_RSP.ack |-> $past(WB_REQ.cyc)) else $error("ack outside a cycle");
  a_upper_zero: assert property (WB_RSP.ack |-> WB_RSP.dat[31:16] == 16'h0) else $error("upper bits set");
  a_other_src_idle: assert property (INT_SRC[6:1] == 6'h00) else $error("foreign source set");
endmodule // pit_timer_asserts
bind pit_timer pit_timer_asserts i_pit_timer_asserts (.CLK(CLK), .RST(RST), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP),
  .INT_SRC(INT_SRC));
`default_nettype wire

// ==== test/pit_timer_tb_top.sv ====
// self-checking bench for the interval timer
// assumes pit_pkg and the checker compiled first
`timescale 1ns/10ps
`default_nettype none
module pit_timer_tb_top;
  import pit_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  pit_wb_req_t req = '0;
  pit_wb_rsp_t rsp;
  logic [6:0]  src;
  logic [31:0] q;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          seed = 28;
  int          p, s, n;
  always #5 clk = ~clk;
  pit_timer i_pit_timer (.CLK(clk), .RST(rst), .WB_REQ(req), .WB_RSP(rsp), .INT_SRC(src));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ack is read just after the edge, so this is its value at that edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge clk);
      t++;
    end while (rsp.ack !== 1'b1 && t < 20);
    q = rsp.dat;
    chk("ack", 32'h1, {31'h0, rsp.ack});
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (src[0] !== 1'b1 && c < 400);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, PIT_OFS_PERIOD, 32'h0);
    chk("period reset", 32'h0, q);
    bus(1'b1, 4'h2, 32'hffff);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      p = $unsigned($random(seed)) % 8;
      s = $unsigned($random(seed)) % 4;
      bus(1'b1, PIT_OFS_CTRL, 32'h0);
      bus(1'b1, PIT_OFS_PERIOD, p);
      bus(1'b1, PIT_OFS_SCALE, s);
      bus(1'b0, PIT_OFS_SCALE, 32'h0);
      chk("scale", s, q);
      bus(1'b1, PIT_OFS_COUNT, 32'h3);
      bus(1'b0, PIT_OFS_COUNT, 32'h0);
      chk("count", 32'h3, q);
      bus(1'b1, PIT_OFS_CTRL, 32'h1);
      wait_irq(n);
      chk("first irq", 32'h1, n >= 4 * (s + 1) - 1 && n <= 4 * (s + 1) + 3);
      chk("other sources", 32'h0, {26'h0, src[6:1]});
      wait_irq(n);
      chk("interval", (p + 1) * (s + 1), n);
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule // pit_timer_tb_top
`default_nettype wire
